/* File: pkg/rsc_regs.vh */
// register map, field positions and timing constants for reset source logic
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// special function register address of the reset source flags
`define RSC_SFR_ADDR 8'hef

// field positions inside reset_source_flags
`define RSC_BIT_PIN 0
`define RSC_BIT_POWER 1
`define RSC_BIT_CLOCK 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SOFT 4
`define RSC_BIT_CMP 5
`define RSC_BIT_MEM 6
`define RSC_BIT_UNUSED 7

// cause flags after a power-on reset: only the power flag set
`define RSC_FLAGS_POR 7'h02
`define RSC_FLAGS_NONE 7'h00
`define RSC_RDATA_IDLE 8'h00

// clock period of i_clock in ns (20 MHz)
`define RSC_CLK_PERIOD_NS 50
// missing clock timeout in ns, longest time, so rounded down
`define RSC_MISS_TIMEOUT_NS 100000
`define RSC_MISS_TIMEOUT_CYC (`RSC_MISS_TIMEOUT_NS / `RSC_CLK_PERIOD_NS)
// least time the system reset stays asserted, rounded up
`define RSC_RESET_HOLD_NS 1000
`define RSC_RESET_HOLD_CYC \
   ((`RSC_RESET_HOLD_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

`endif

/* File: verilog/rsc_missing_clock.v */
// missing clock detector: flags a monitored clock that stops toggling
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_missing_clock #(
   parameter TIMEOUT_CYC = `RSC_MISS_TIMEOUT_CYC,
   parameter CNT_W = 16
) (
   // clock and reset
   input wire i_clock,
   input wire i_sys_rst,
   // monitored clock, asynchronous to i_clock
   input wire i_monitored_clock,
   // control and result
   input wire i_enable,
   output reg o_missing
);

   localparam [CNT_W-1:0] LIMIT = TIMEOUT_CYC[CNT_W-1:0];

   reg sync_a;
   reg sync_b;
   reg last;
   reg [CNT_W-1:0] count;
   wire toggled;

   // two flip-flop synchroniser for the monitored clock
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last <= 1'b0;
      end else begin
         sync_a <= i_monitored_clock;
         sync_b <= sync_a;
         last <= sync_b;
      end
   end

   assign toggled = sync_b ^ last;

   // one-shot: restarts on every edge, fires when no edge for the timeout
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count <= {CNT_W{1'b0}};
         o_missing <= 1'b0;
      end else if (!i_enable || toggled) begin
         count <= {CNT_W{1'b0}};
         o_missing <= 1'b0;
      end else if (count >= LIMIT) begin
         o_missing <= 1'b1;
      end else begin
         count <= count + 1'b1;
         o_missing <= 1'b0;
      end
   end

endmodule

/* File: verilog/rsc_reset_source.v */
// reset source control: reset enables, cause flags and system reset output
//
// Summary of operation
// - bit 6 reads 1 after memory error reset
// - bit 5 reads 1 after comparator reset
// - bit 4 written 1 forces system reset
// - bit 4 reads 1 after software reset
// - bit 3 reads 1 after watchdog reset
// - bit 2 written 1 enables missing clock detector
// - enabled detector resets when clock stops
// - bit 1 written 1 enables supply monitor reset
// - bit 1 reads 1 after power-on/supply reset
// - other flags meaningless while bit 1 set
// - bit 0 reads 1 after pin reset
// - bit 2 written 0 disables detector
// - comparator low holds device in reset
// - internal resets never drive reset pin
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_reset_source #(
   parameter MISS_TIMEOUT_CYC = `RSC_MISS_TIMEOUT_CYC,
   parameter RESET_HOLD_CYC = `RSC_RESET_HOLD_CYC,
   parameter HOLD_W = 8
) (
   // clock and power-on reset
   input wire i_clock,
   input wire i_sys_rst,
   // special function register port
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire [7:0] i_sfr_wdata,
   output reg [7:0] o_sfr_rdata,
   // asynchronous reset sources
   input wire i_pin_reset_n,
   input wire i_supply_ok,
   input wire i_comparator_out,
   input wire i_monitored_clock,
   // reset sources on i_clock
   input wire i_watchdog_overflow,
   input wire i_memory_error,
   // system reset to the rest of the device
   output reg o_system_reset
);

   localparam [HOLD_W-1:0] HOLD_LOAD = RESET_HOLD_CYC[HOLD_W-1:0];
   localparam [HOLD_W-1:0] HOLD_ZERO = {HOLD_W{1'b0}};

   // cause flags, bits 6..0 of reset_source_flags
   reg [6:0] flags;
   reg [6:0] next_flags;
   // enables written by software
   reg cmp_enable;
   reg clock_watch_enable;
   reg supply_enable;
   // reset stretch counter
   reg [HOLD_W-1:0] hold;
   // synchronisers for pin, supply monitor and comparator
   reg pin_a;
   reg pin_b;
   reg supply_a;
   reg supply_b;
   reg cmp_a;
   reg cmp_b;

   wire clock_missing;
   wire sfr_hit;
   wire sfr_wr;
   wire act_pin;
   wire act_supply;
   wire act_clock;
   wire act_cmp;
   wire act_wdt;
   wire act_mem;
   wire act_soft;
   wire any_act;

   // missing clock detector instance
   // detector is held cleared whenever its enable is low
   rsc_missing_clock #(
      .TIMEOUT_CYC(MISS_TIMEOUT_CYC)
   ) u_clock_watch (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_monitored_clock(i_monitored_clock),
      .i_enable(clock_watch_enable),
      .o_missing(clock_missing)
   );

   // pin synchroniser; idle high means no reset request
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_a <= 1'b1;
         pin_b <= 1'b1;
      end else begin
         pin_a <= i_pin_reset_n;
         pin_b <= pin_a;
      end
   end

   // supply monitor synchroniser; idle high means supply good
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         supply_a <= 1'b1;
         supply_b <= 1'b1;
      end else begin
         supply_a <= i_supply_ok;
         supply_b <= supply_a;
      end
   end

   // comparator synchroniser; idle high means inputs not crossed
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmp_a <= 1'b1;
         cmp_b <= 1'b1;
      end else begin
         cmp_a <= i_comparator_out;
         cmp_b <= cmp_a;
      end
   end

   // register decode; writes are refused while the device is in reset
   // a write in reset could re-arm a source before the cause is read
   assign sfr_hit = (i_sfr_addr == `RSC_SFR_ADDR);
   assign sfr_wr = sfr_hit && i_sfr_write && !o_system_reset;

   // pin is only sensed, never driven by this block
   assign act_pin = !pin_b;
   assign act_supply = supply_enable && !supply_b;
   assign act_clock = clock_watch_enable && clock_missing;
   // comparator low holds reset for as long as it stays low
   assign act_cmp = cmp_enable && !cmp_b;
   assign act_wdt = i_watchdog_overflow;
   assign act_mem = i_memory_error;
   assign act_soft = sfr_wr && i_sfr_wdata[`RSC_BIT_SOFT];
   assign any_act = act_pin | act_supply | act_clock | act_cmp |
      act_wdt | act_mem | act_soft;

   // cause selection by fixed priority, one flag only
   // sources rarely collide; the order only settles ties
   always @* begin
      next_flags = `RSC_FLAGS_NONE;
      if (act_pin) begin
         next_flags[`RSC_BIT_PIN] = 1'b1;
      end else if (act_supply) begin
         next_flags[`RSC_BIT_POWER] = 1'b1;
      end else if (act_clock) begin
         next_flags[`RSC_BIT_CLOCK] = 1'b1;
      end else if (act_cmp) begin
         next_flags[`RSC_BIT_CMP] = 1'b1;
      end else if (act_wdt) begin
         next_flags[`RSC_BIT_WDT] = 1'b1;
      end else if (act_mem) begin
         next_flags[`RSC_BIT_MEM] = 1'b1;
      end else begin
         next_flags[`RSC_BIT_SOFT] = 1'b1;
      end
   end

   // cause flags: only a reset event changes them, writes never do
   // no write path, so a stray store cannot fake a cause
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flags <= `RSC_FLAGS_POR;
      end else if (any_act) begin
         flags <= next_flags;
      end
   end

   // enables: set and cleared by writes, cleared by every reset; the comparator's is kept only while its own source is active
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmp_enable <= 1'b0;
         clock_watch_enable <= 1'b0;
         supply_enable <= 1'b0;
      end else if (any_act || o_system_reset) begin
         // comparator enable kept only while its own source is active
         cmp_enable <= act_cmp;
         clock_watch_enable <= 1'b0;
         supply_enable <= 1'b0;
      end else if (sfr_wr) begin
         cmp_enable <= i_sfr_wdata[`RSC_BIT_CMP];
         clock_watch_enable <= i_sfr_wdata[`RSC_BIT_CLOCK];
         supply_enable <= i_sfr_wdata[`RSC_BIT_POWER];
      end
   end

   // system reset: asserted while a source is active, then stretched
   // reload on every active cycle keeps a level source in reset
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold <= HOLD_LOAD;
         o_system_reset <= 1'b1;
      end else if (any_act) begin
         hold <= HOLD_LOAD;
         o_system_reset <= 1'b1;
      end else if (hold != HOLD_ZERO) begin
         hold <= hold - 1'b1;
         o_system_reset <= 1'b1;
      end else begin
         hold <= HOLD_ZERO;
         o_system_reset <= 1'b0;
      end
   end

   // read data: flags in bits 6..0, bit 7 always zero
   // registered, so read data trails the address by one cycle
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_sfr_rdata <= `RSC_RDATA_IDLE;
      end else if (sfr_hit) begin
         o_sfr_rdata <= {1'b0, flags};
      end else begin
         o_sfr_rdata <= `RSC_RDATA_IDLE;
      end
   end

endmodule

/* File: test/rsc_reset_source_props.sv */
// assertions on the reset source block ports
`timescale 1ns/100ps
module rsc_reset_source_props #(
   parameter RESET_HOLD_CYC = 20
) (
   // clock, reset and register port
   input wire i_clock,
   input wire i_sys_rst,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire [7:0] i_sfr_wdata,
   input wire [7:0] o_sfr_rdata,
   // reset sources and result
   input wire i_pin_reset_n,
   input wire i_watchdog_overflow,
   input wire i_memory_error,
   input wire o_system_reset
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // write that the block takes
   wire wr_hit = i_sfr_write && i_sfr_addr == 8'hef && !o_system_reset;
   // cycles the system reset has been high, saturating
   reg [7:0] high_count;
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst)
         high_count <= 8'h00;
      else if (!o_system_reset)
         high_count <= 8'h00;
      else if (high_count != 8'hff)
         high_count <= high_count + 8'h01;
   end
   a_unused_zero: assert property (o_sfr_rdata[7] == 1'b0)
      else $error("unused bit read as one");
   a_rdata_idle: assert property (
      i_sfr_addr != 8'hef |=> o_sfr_rdata == 8'h00)
      else $error("read data not zero off address");
   a_soft_force: assert property (
      wr_hit && i_sfr_wdata[4] |=> o_system_reset)
      else $error("software write did not reset");
   a_pin_reset: assert property (
      !i_pin_reset_n [*4] |-> o_system_reset)
      else $error("pin low without reset");
   a_wdt_reset: assert property (i_watchdog_overflow |=> o_system_reset)
      else $error("watchdog without reset");
   a_mem_reset: assert property (i_memory_error |=> o_system_reset)
      else $error("memory error without reset");
   a_reset_hold: assert property (
      $rose(o_system_reset) |-> o_system_reset [*3])
      else $error("system reset too short");
   a_por_hold: assert property (
      $fell(i_sys_rst) |-> o_system_reset [*2])
      else $error("power-on reset too short");
   a_hold_length: assert property (
      $fell(o_system_reset) |-> high_count > RESET_HOLD_CYC)
      else $error("system reset shorter than hold count");
endmodule

/* File: test/rsc_src_model.sv */
// on-chip reset sources, driven on command from the bench
`timescale 1ns/100ps
module rsc_src_model (
   // command: 0 quiet, 1 pin, 2 supply, 3 clock stop, 4 cmp, 5 wdt, 6 mem
   input wire [2:0] i_cmd,
   // source outputs
   output wire o_pin_reset_n,
   output wire o_supply_ok,
   output wire o_comparator_out,
   output wire o_watchdog_overflow,
   output wire o_memory_error,
   output reg o_monitored_clock
);
   // level sources follow the command
   assign o_pin_reset_n = i_cmd != 3'h1;
   assign o_supply_ok = i_cmd != 3'h2;
   assign o_comparator_out = i_cmd != 3'h4;
   assign o_watchdog_overflow = i_cmd == 3'h5;
   assign o_memory_error = i_cmd == 3'h6;
   // watched clock runs free unless told to stop
   initial o_monitored_clock = 1'b0;
   always #37 if (i_cmd != 3'h3) o_monitored_clock = ~o_monitored_clock;
endmodule

/* File: test/rsc_reset_source_bench.sv */
// self-checking bench for the reset source block
`timescale 1ns/100ps
module rsc_reset_source_bench;
   reg i_clock = 1'b0;
   reg i_sys_rst = 1'b1;
   reg [7:0] addr = 8'h00;
   reg sfr_write = 1'b0;
   reg [7:0] wdata = 8'h00;
   reg [2:0] cmd = 3'h0;
   reg seen = 1'b0;
   wire [7:0] rdata;
   wire sys_reset, pin_n, sup_ok, cmp, mclk, wdt, mem;
   integer miscompares = 0;
   integer comparisons = 0;
   // 50 ns clock
   always #25 i_clock = ~i_clock;
   // note any system reset
   always @(posedge i_clock) if (sys_reset) seen <= 1'b1;
   rsc_src_model i_src (.i_cmd(cmd), .o_pin_reset_n(pin_n),
      .o_supply_ok(sup_ok), .o_comparator_out(cmp),
      .o_watchdog_overflow(wdt), .o_memory_error(mem),
      .o_monitored_clock(mclk));
   rsc_reset_source #(.MISS_TIMEOUT_CYC(20), .RESET_HOLD_CYC(2)) i_dut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sfr_addr(addr),
      .i_sfr_write(sfr_write), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
      .i_pin_reset_n(pin_n), .i_supply_ok(sup_ok), .i_comparator_out(cmp),
      .i_monitored_clock(mclk), .i_watchdog_overflow(wdt),
      .i_memory_error(mem), .o_system_reset(sys_reset));
   task check(input string name, input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d miscompares %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         while (sys_reset !== 1'b0 && n < 200) begin
            @(posedge i_clock);
            #5 n = n + 1;
         end
         if (n == 200) begin
            check("reset release", 8'h01, 8'h00);
            stop_test;
         end
      end
   endtask
   task put(input [7:0] d);
      begin
         @(posedge i_clock);
         #5 addr = 8'hef; // whole-byte write
         sfr_write = 1'b1;
         wdata = d;
         @(posedge i_clock);
         #5 sfr_write = 1'b0;
      end
   endtask
   task get(input [7:0] exp);
      begin
         @(posedge i_clock);
         #5 addr = 8'hef;
         @(posedge i_clock);
         @(posedge i_clock);
         #5 check("flags", rdata, exp);
         addr = 8'h00;
      end
   endtask
   task run_src(input [2:0] c, input [7:0] en, input [7:0] exp, input hit);
      reg held;
      begin
         held = hit && (c == 3'h1 || c >= 3'h4);
         seen = 1'b0;
         put(en);
         @(posedge i_clock);
         #5 cmd = c;
         repeat (30) @(posedge i_clock);
         #5 check("reset held", {7'h00, sys_reset}, {7'h00, held});
         cmd = 3'h0;
         wait_idle;
         check("reset seen", {7'h00, seen}, {7'h00, hit});
         get(exp);
      end
   endtask
   task t_power_on;
      begin
         wait_idle;
         get(8'h02);
         $display("test power-on done");
      end
   endtask
   task t_software;
      begin
         run_src(3'h0, 8'h10, 8'h10, 1'b1);
         run_src(3'h0, 8'hc9, 8'h10, 1'b0);
         $display("test software reset done");
      end
   endtask
   task t_watchdog;
      begin
         run_src(3'h5, 8'h00, 8'h08, 1'b1);
         $display("test watchdog reset done");
      end
   endtask
   task t_memory;
      begin
         run_src(3'h6, 8'h00, 8'h40, 1'b1);
         $display("test memory error reset done");
      end
   endtask
   task t_pin;
      begin
         run_src(3'h1, 8'h00, 8'h01, 1'b1);
         $display("test pin reset done");
      end
   endtask
   task t_comparator;
      begin
         run_src(3'h4, 8'h00, 8'h01, 1'b0);
         run_src(3'h4, 8'h20, 8'h20, 1'b1);
         $display("test comparator reset done");
      end
   endtask
   task t_supply;
      begin
         run_src(3'h2, 8'h00, 8'h20, 1'b0);
         run_src(3'h2, 8'h02, 8'h02, 1'b1);
         $display("test supply monitor reset done");
      end
   endtask
   task t_missing_clock;
      begin
         put(8'h04);
         run_src(3'h3, 8'h00, 8'h02, 1'b0);
         run_src(3'h3, 8'h04, 8'h04, 1'b1);
         $display("test missing clock reset done");
      end
   endtask
   task t_reset_again;
      begin
         @(posedge i_clock);
         #5 i_sys_rst = 1'b1;
         repeat (3) @(posedge i_clock);
         #5 i_sys_rst = 1'b0;
         wait_idle;
         get(8'h02);
         $display("test second power-on done");
      end
   endtask
   initial begin
      repeat (12) @(posedge i_clock);
      #5 i_sys_rst = 1'b0;
      t_power_on;
      t_software;
      t_watchdog;
      t_memory;
      t_pin;
      t_comparator;
      t_supply;
      t_missing_clock;
      t_reset_again;
      stop_test;
   end
endmodule
bind rsc_reset_source rsc_reset_source_props #(
   .RESET_HOLD_CYC(RESET_HOLD_CYC)) i_props (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
   .i_sfr_write(i_sfr_write), .i_sfr_wdata(i_sfr_wdata),
   .o_sfr_rdata(o_sfr_rdata), .i_pin_reset_n(i_pin_reset_n),
   .i_watchdog_overflow(i_watchdog_overflow),
   .i_memory_error(i_memory_error), .o_system_reset(o_system_reset));
